// >>> rtl/sbrg_top.sv
/*
 * Serial baud timer with AXI4-Lite register slave.
 * Assumes an AXI4-Lite master on aclk keeping the usual valid/ready protocol.
 */
// Local design decisions: the address map and the AXI4-Lite register port.
// What this block does
// - Free running timer, period from register pair.
// - Async multiplier from speed and width selects.
// - Sync mode ignores high speed select.
// - Period register write clears timer one cycle after the register updates.
// - Async 8-bit normal: divide by 64(n+1).
// - Timer 8-bit after reset; width select widens.
`timescale 1ns/1ps
module sbrg_top
   import sbrg_pkg::*;
(
   // Clock and reset.
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write address.
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [3:0]  s_axi_awaddr,
   // AXI4-Lite write data.
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   // AXI4-Lite write response.
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   output logic [1:0]       s_axi_bresp,
   // AXI4-Lite read address.
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   input  wire logic [3:0]  s_axi_araddr,
   // AXI4-Lite read data.
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   // Receiver status and baud output.
   input  wire logic        receiver_idle_flag,
   output logic             baud_tick
);
   logic [7:0]  plow_q, plow_d;     // Low period register.
   logic [7:0]  phigh_q, phigh_d;   // High period register.
   logic [3:0]  mode_q, mode_d;     // Mode bits.
   logic        aw_q, aw_d;         // Write address held.
   logic [3:0]  awa_q, awa_d;       // Held write address.
   logic        w_q, w_d;           // Write data held.
   logic [31:0] wd_q, wd_d;         // Held write data.
   logic        wst_q, wst_d;       // Held byte lane 0 strobe.
   logic        bv_q, bv_d;         // Write response valid.
   logic [1:0]  br_q, br_d;         // Write response code.
   logic        rv_q, rv_d;         // Read data valid.
   logic [31:0] rd_q, rd_d;         // Read data.
   logic [1:0]  rr_q, rr_d;         // Read response code.
   logic        restart_q, restart_d; // Period write pulse.
   logic        rxi_s1_q, rxi_s2_q;   // Idle flag synchroniser.
   logic [15:0] tcount;             // Live timer count.
   logic        do_write;           // Both write halves present.
   sbrg_mode_t  mode_s;             // Mode as struct.

   assign mode_s = sbrg_mode_t'(mode_q);
   assign do_write = aw_q && w_q && !bv_q;

   // Write channel and register update.
   always_comb begin
      aw_d      = aw_q;
      awa_d     = awa_q;
      w_d       = w_q;
      wd_d      = wd_q;
      wst_d     = wst_q;
      bv_d      = bv_q;
      br_d      = br_q;
      plow_d    = plow_q;
      phigh_d   = phigh_q;
      mode_d    = mode_q;
      restart_d = 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_d  = 1'b1;
         awa_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_d   = 1'b1;
         wd_d  = s_axi_wdata;
         wst_d = s_axi_wstrb[0];
      end
      if (do_write) begin
         aw_d = 1'b0;
         w_d  = 1'b0;
         bv_d = 1'b1;
         br_d = SBRG_RESP_OKAY;
         unique case ({awa_q[3:2], 2'b00})
            SBRG_OFF_PERIOD_LOW: begin
               if (wst_q) begin
                  plow_d    = wd_q[7:0];
                  restart_d = 1'b1;
               end
            end
            SBRG_OFF_PERIOD_HIGH: begin
               if (wst_q) begin
                  phigh_d   = wd_q[7:0];
                  restart_d = 1'b1;
               end
            end
            SBRG_OFF_MODE: begin
               if (wst_q) begin
                  mode_d = wd_q[3:0];
               end
            end
            default: begin
               br_d = SBRG_RESP_SLVERR;
            end
         endcase
      end
      if (bv_q && s_axi_bready) begin
         bv_d = 1'b0;
      end
   end

   // Read channel.
   always_comb begin
      rv_d = rv_q;
      rd_d = rd_q;
      rr_d = rr_q;
      if (s_axi_arvalid && s_axi_arready) begin
         rv_d = 1'b1;
         rr_d = SBRG_RESP_OKAY;
         unique case ({s_axi_araddr[3:2], 2'b00})
            SBRG_OFF_PERIOD_LOW:  rd_d = {24'h000000, plow_q};
            SBRG_OFF_PERIOD_HIGH: rd_d = {24'h000000, phigh_q};
            SBRG_OFF_MODE:        rd_d = {28'h0000000, mode_q};
            SBRG_OFF_STATUS:      rd_d = {15'h0000, rxi_s2_q, tcount};
            default: begin
               rd_d = 32'h00000000;
               rr_d = SBRG_RESP_SLVERR;
            end
         endcase
      end else if (rv_q && s_axi_rready) begin
         rv_d = 1'b0;
      end
   end

   // Register all bus and configuration state.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_q      <= 1'b0;
         awa_q     <= 4'h0;
         w_q       <= 1'b0;
         wd_q      <= 32'h00000000;
         wst_q     <= 1'b0;
         bv_q      <= 1'b0;
         br_q      <= SBRG_RESP_OKAY;
         rv_q      <= 1'b0;
         rd_q      <= 32'h00000000;
         rr_q      <= SBRG_RESP_OKAY;
         plow_q    <= SBRG_PERIOD_RST;
         phigh_q   <= SBRG_PERIOD_RST;
         mode_q    <= SBRG_MODE_RST;
         restart_q <= 1'b0;
         rxi_s1_q  <= 1'b0;
         rxi_s2_q  <= 1'b0;
      end else begin
         aw_q      <= aw_d;
         awa_q     <= awa_d;
         w_q       <= w_d;
         wd_q      <= wd_d;
         wst_q     <= wst_d;
         bv_q      <= bv_d;
         br_q      <= br_d;
         rv_q      <= rv_d;
         rd_q      <= rd_d;
         rr_q      <= rr_d;
         plow_q    <= plow_d;
         phigh_q   <= phigh_d;
         mode_q    <= mode_d;
         restart_q <= restart_d;
         rxi_s1_q  <= receiver_idle_flag;
         rxi_s2_q  <= rxi_s1_q;
      end
   end

   // Handshake outputs; each half is accepted once and held until the response.
   assign s_axi_awready = !aw_q && !bv_q;
   assign s_axi_wready  = !w_q && !bv_q;
   assign s_axi_bvalid  = bv_q;
   assign s_axi_bresp   = br_q;
   assign s_axi_arready = !rv_q;
   assign s_axi_rvalid  = rv_q;
   assign s_axi_rdata   = rd_q;
   assign s_axi_rresp   = rr_q;

   // Timer core.
   sbrg_timer u_timer (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .mode      (mode_s),
      .period    ({phigh_q, plow_q}),
      .restart   (restart_q),
      .baud_tick (baud_tick),
      .count     (tcount)
   );

   // Period write produces a restart pulse one cycle later.
   chk_period_restart: assert property (@(posedge aclk) disable iff (!aresetn)
      do_write && wst_q && (awa_q[3:2] == 2'b00 || awa_q[3:2] == 2'b01) |=> restart_q)
      else $error("period write gave no restart");
   // Width select is clear after reset.
   chk_reset_narrow: assert property (@(posedge aclk)
      !aresetn |=> !mode_q[SBRG_MODE_WIDE_BIT]) else $error("wide select set after reset");
   // Write response follows the commit.
   chk_bresp_follow: assert property (@(posedge aclk) disable iff (!aresetn)
      do_write |=> s_axi_bvalid) else $error("no write response");
endmodule

// >>> shared/sbrg_pkg.sv
/*
 * Constants and carrier types for the serial baud timer block.
 * Assumes a 32-bit AXI4-Lite register bus and one 20 MHz clock.
 */
package sbrg_pkg;
   // Register byte offsets.
   localparam logic [3:0] SBRG_OFF_PERIOD_LOW  = 4'h0;
   localparam logic [3:0] SBRG_OFF_PERIOD_HIGH = 4'h4;
   localparam logic [3:0] SBRG_OFF_MODE        = 4'h8;
   localparam logic [3:0] SBRG_OFF_STATUS      = 4'hC;
   // Mode register field positions.
   localparam int SBRG_MODE_HS_BIT   = 0;
   localparam int SBRG_MODE_WIDE_BIT = 1;
   localparam int SBRG_MODE_SYNC_BIT = 2;
   localparam int SBRG_MODE_EN_BIT   = 3;
   // Reset values.
   localparam logic [7:0] SBRG_PERIOD_RST = 8'h00;
   localparam logic [3:0] SBRG_MODE_RST   = 4'h0;
   // Prescale divisors: async low speed 8 bit, async 16 bit or high speed, sync or both set.
   localparam logic [5:0] SBRG_DIV_64 = 6'h3F;
   localparam logic [5:0] SBRG_DIV_16 = 6'h0F;
   localparam logic [5:0] SBRG_DIV_4  = 6'h03;
   // AXI responses.
   localparam logic [1:0] SBRG_RESP_OKAY   = 2'h0;
   localparam logic [1:0] SBRG_RESP_SLVERR = 2'h2;

   // Operating mode as seen by the timer.
   typedef struct packed {
      logic enable;
      logic sync_mode;
      logic wide_timer_select;
      logic high_speed_select;
   } sbrg_mode_t;
endpackage

// >>> rtl/sbrg_timer.sv
/*
 * Baud timer core: prescaler plus period up counter, emits a tick per period.
 * Assumes configuration comes from registers on the same clock.
 */
`timescale 1ns/1ps
module sbrg_timer
   import sbrg_pkg::*;
(
   // Clock and reset.
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // Configuration.
   input  wire sbrg_mode_t  mode,
   input  wire logic [15:0] period,
   input  wire logic        restart,
   // Outputs.
   output logic             baud_tick,
   output logic [15:0]      count
);
   logic [5:0]  pre_q, pre_d;     // Prescale counter.
   logic [15:0] cnt_q, cnt_d;     // Period counter.
   logic        tick_q, tick_d;   // Registered tick.
   logic [5:0]  div_lim;          // Prescale terminal value.
   logic [15:0] per_eff;          // Effective period.

   // Divisor selection and effective period width.
   always_comb begin
      if (mode.sync_mode) begin
         div_lim = SBRG_DIV_4;
      end else if (mode.wide_timer_select && mode.high_speed_select) begin
         div_lim = SBRG_DIV_4;
      end else if (mode.wide_timer_select || mode.high_speed_select) begin
         div_lim = SBRG_DIV_16;
      end else begin
         div_lim = SBRG_DIV_64;
      end
      // Narrow mode ignores the high byte.
      per_eff = mode.wide_timer_select ? period : {8'h00, period[7:0]};
   end

   // Free-running counter; a period write clears it.
   always_comb begin
      pre_d  = pre_q;
      cnt_d  = cnt_q;
      tick_d = 1'b0;
      if (restart || !mode.enable) begin
         pre_d = 6'h00;
         cnt_d = 16'h0000;
      end else if (pre_q >= div_lim) begin
         pre_d = 6'h00;
         if (cnt_q >= per_eff) begin
            cnt_d  = 16'h0000;
            tick_d = 1'b1;
         end else begin
            cnt_d = cnt_q + 16'h0001;
         end
      end else begin
         pre_d = pre_q + 6'h01;
      end
   end

   // State registers.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pre_q  <= 6'h00;
         cnt_q  <= 16'h0000;
         tick_q <= 1'b0;
      end else begin
         pre_q  <= pre_d;
         cnt_q  <= cnt_d;
         tick_q <= tick_d;
      end
   end

   assign baud_tick = tick_q;
   assign count     = cnt_q;

   // Restart clears the counter next cycle.
   chk_restart_clears: assert property (@(posedge aclk) disable iff (!aresetn)
      restart |=> (cnt_q == 16'h0000) && (pre_q == 6'h00)) else $error("restart did not clear timer");
   // Normal 8-bit async divides by 64 per count step.
   chk_div64_step: assert property (@(posedge aclk) disable iff (!aresetn)
      (mode == 4'b1000) && !restart && (pre_q == SBRG_DIV_64) |=> (pre_q == 6'h00))
      else $error("prescale 64 wrap wrong");
   // Sync mode uses divide by four whatever the speed bit.
   chk_sync_div: assert property (@(posedge aclk) disable iff (!aresetn)
      mode.enable && mode.sync_mode && !restart && (pre_q == 6'h03) |=> (pre_q == 6'h00))
      else $error("sync prescale wrong");
   // Prescale never exceeds selected limit while the mode holds; a mode change can leave it above for a cycle.
   chk_pre_bound: assert property (@(posedge aclk) disable iff (!aresetn)
      $stable(mode) && !restart |=> pre_q <= div_lim) else $error("prescale beyond limit");
   // Narrow counter never passes the low period byte once inside it.
   // A switch from wide to narrow may leave a larger count until the next wrap, which is legal.
   chk_narrow_cnt: assert property (@(posedge aclk) disable iff (!aresetn)
      !mode.wide_timer_select && $stable(period) && $stable(mode) && (cnt_q <= {8'h00, period[7:0]})
      |=> cnt_q <= {8'h00, period[7:0]})
      else $error("narrow count exceeds low byte");
   // Tick follows a terminal count.
   chk_tick_cause: assert property (@(posedge aclk) disable iff (!aresetn)
      baud_tick |-> $past(cnt_q >= per_eff) && $past(pre_q >= div_lim)) else $error("tick without wrap");
   // Wide counter never passes the full period.
   chk_wide_cnt: assert property (@(posedge aclk) disable iff (!aresetn)
      mode.wide_timer_select && $stable(period) && $stable(mode) |=> cnt_q <= period)
      else $error("wide count exceeds period");
endmodule

// >>> dv/tb_top.sv
/*
 * Self-checking bench for the serial baud timer with its AXI4-Lite register slave.
 * Assumes sbrg_pkg and the rtl files are compiled first; one 20 MHz clock.
 */
`timescale 1ns/1ps
module tb_top;
   import sbrg_pkg::*;

   // Clock, reset and status input.
   logic        aclk;
   logic        aresetn;
   logic        receiver_idle_flag;
   // Bus signals driven by the bench.
   logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic [31:0] s_axi_wdata;
   // Outputs of the block.
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, baud_tick;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   // Expected answers: {is_read, resp, data}, oldest first.
   logic [34:0] exp_q[$];
   logic [34:0] note;
   logic [31:0] seed;
   int          mismatches;
   int          cmp_count;

   // Block under test.
   sbrg_top dut_u (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .receiver_idle_flag(receiver_idle_flag), .baud_tick(baud_tick));

   // Free running 50 ns clock.
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end

   // Compares one value and counts the outcome.
   task automatic check(input logic [34:0] seen, input logic [34:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // Counts waited cycles and ends the run if a wait never completes.
   task automatic bump(inout int n);
      n++;
      if (n > 40000) begin
         mismatches++;
         finish_test();
      end
   endtask

   // Xorshift source for period values.
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // One write: address and data offered together, each released when taken.
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
      bit aw_done, w_done;
      int n;
      aw_done = 0;
      w_done = 0;
      n = 0;
      @(posedge aclk);
      exp_q.push_back({1'b0, r, 32'h0000_0000});
      s_axi_awvalid <= 1'b1;
      s_axi_awaddr  <= a;
      s_axi_wvalid  <= 1'b1;
      s_axi_wdata   <= d;
      s_axi_bready  <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge aclk);
         bump(n);
         if (!aw_done && s_axi_awready) begin
            aw_done = 1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_done && s_axi_wready) begin
            w_done = 1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do begin @(posedge aclk); bump(n); end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask

   // One read; the expected word is noted for the monitor.
   task automatic rd(input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge aclk);
      exp_q.push_back({1'b1, SBRG_RESP_OKAY, d});
      s_axi_arvalid <= 1'b1;
      s_axi_araddr  <= a;
      s_axi_rready  <= 1'b1;
      do begin @(posedge aclk); bump(n); end while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do begin @(posedge aclk); bump(n); end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
   endtask

   // Returns the cycles from the call, or from the previous tick, to the next tick.
   task automatic wait_tick(output int n);
      n = 0;
      do begin @(posedge aclk); bump(n); end while (!baud_tick);
   endtask

   // Monitor: each completed response is matched against the oldest note.
   always @(posedge aclk) begin
      if (s_axi_bvalid && s_axi_bready) begin
         note = exp_q.pop_front();
         check({1'b0, s_axi_bresp, 32'h0000_0000}, note);
      end
      if (s_axi_rvalid && s_axi_rready) begin
         note = exp_q.pop_front();
         check({1'b1, s_axi_rresp, s_axi_rdata}, note);
      end
   end

   // Watchdog sized well beyond the longest expected run.
   initial begin
      #4000000;
      mismatches++;
      finish_test();
   end

   // Main sequence.
   initial begin
      static logic [3:0] md[7] = '{4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'h8};
      static logic [7:0] hi[7] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h01};
      logic [7:0]  lo;
      logic [31:0] r;
      int          gap, dv, cnt;
      aresetn = 1'b0;
      receiver_idle_flag = 1'b0;
      s_axi_awvalid = 1'b0;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      s_axi_awaddr = 4'h0;
      s_axi_araddr = 4'h0;
      s_axi_wstrb = 4'hF;
      s_axi_wdata = 32'h0000_0000;
      seed = 32'h44BA4236;
      mismatches = 0;
      cmp_count = 0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      // Reset state: narrow, normal speed, zero period.
      rd(SBRG_OFF_PERIOD_LOW, 32'h0000_0000);
      rd(SBRG_OFF_PERIOD_HIGH, 32'h0000_0000);
      rd(SBRG_OFF_MODE, 32'h0000_0000);
      rd(SBRG_OFF_STATUS, 32'h0000_0000);
      receiver_idle_flag <= 1'b1;
      repeat (4) @(posedge aclk);
      rd(SBRG_OFF_STATUS, 32'h0001_0000);
      // Status is read only; a write is refused.
      wr(SBRG_OFF_STATUS, 32'h0000_0001, SBRG_RESP_SLVERR);
      // All four async speed and width combinations plus narrow sync at both speeds, with a random low period.
      for (int i = 0; i < 7; i++) begin
         r = xs();
         lo = {4'h0, r[3:0]};
         wr(SBRG_OFF_PERIOD_HIGH, {24'h0, hi[i]}, SBRG_RESP_OKAY);
         wr(SBRG_OFF_PERIOD_LOW, {24'h0, lo}, SBRG_RESP_OKAY);
         wr(SBRG_OFF_MODE, {28'h0, md[i]}, SBRG_RESP_OKAY);
         rd(SBRG_OFF_MODE, {28'h0, md[i]});
         rd(SBRG_OFF_PERIOD_HIGH, {24'h0, hi[i]});
         dv = md[i][2] ? 4 : (md[i][0] && md[i][1]) ? 4 : (md[i][0] || md[i][1]) ? 16 : 64;
         cnt = md[i][1] ? int'({hi[i], lo}) + 1 : int'(lo) + 1;
         wait_tick(gap);
         wait_tick(gap);
         check(35'(gap), 35'(dv * cnt));
      end
      // A period write in mid-count restarts the timer one cycle after the register updates.
      wr(SBRG_OFF_PERIOD_HIGH, 32'h0000_0000, SBRG_RESP_OKAY);
      wr(SBRG_OFF_PERIOD_LOW, 32'h0000_00FF, SBRG_RESP_OKAY);
      wr(SBRG_OFF_MODE, 32'h0000_0008, SBRG_RESP_OKAY);
      wait_tick(gap);
      repeat (100) @(posedge aclk);
      // The clear lands on the edge at which the response is seen, so the first
      // tick comes one full new period plus one cycle later; without it the old
      // count would run on and tick far sooner.
      wr(SBRG_OFF_PERIOD_LOW, 32'h0000_0002, SBRG_RESP_OKAY);
      wait_tick(gap);
      check(35'(gap), 35'((int'(SBRG_DIV_64) + 1) * 3 + 1));
      finish_test();
   end
endmodule
